// ---- pkg/cdu_map.vh ----
// address map, field positions, reset values and timing of the config loader
`ifndef CDU_MAP_VH
`define CDU_MAP_VH

// clock rate and start-up timing
`define CDU_CLK_MHZ         200
`define CDU_SEQ_DELAY_NS    500000
`define CDU_SEQ_DELAY_CYC   ((`CDU_SEQ_DELAY_NS * `CDU_CLK_MHZ) / 1000)

// volatile configuration window, pages 0 to 4
`define CDU_RAM_WORDS       160
`define CDU_RAM_LAST        8'h9F
`define CDU_RAM_END         8'hA0
`define CDU_PAGE_LAST       5'h1F

// margining fields inside the configuration window, six channels each
`define CDU_MARGIN_CH       6
`define CDU_ADDR_UPPER      8'h40
`define CDU_ADDR_LOWER      8'h48
`define CDU_ADDR_CODE       8'h58

// control and status registers
`define CDU_ADDR_UPDCTRL    16'h00D7
`define CDU_ADDR_RELOAD     16'h00D8
`define CDU_ADDR_STATUS     16'h00D9
`define CDU_UPD_TRANSP_BIT  0
`define CDU_UPD_COMMIT_BIT  1
`define CDU_UPD_ERASE_BIT   2
`define CDU_RELOAD_BIT      0
`define CDU_STAT_DONE_BIT   0
`define CDU_STAT_BUSY_BIT   1
`define CDU_STAT_PEND_BIT   2
`define CDU_UPD_RESET       1'b0

// configuration EEPROM cell, 0xF800 to 0xF9FF
`define CDU_NV_HI           7'h7C
`define CDU_NV_WORDS        512
`define CDU_NV_BLANK        8'hFF

`endif

// ---- logic/cdu_clip.v ----
// one margining channel: limit clipping and output buffer enable
`timescale 1ns/1ps
`default_nettype none
module cdu_clip (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       enable,
  input  wire [7:0] code,
  input  wire [7:0] lower,
  input  wire [7:0] upper,
  output reg  [7:0] clip_code,
  output reg        drive_en
);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clip_code <= 8'h00;
      drive_en  <= 1'b0;
    end else begin
      if (code < lower) begin
        clip_code <= lower;
      end else if (code > upper) begin
        clip_code <= upper;
      end else begin
        clip_code <= code;
      end
      // crossed limits keep the buffer off while they stay crossed
      drive_en <= enable & ~(lower > upper);
    end
  end

endmodule
`default_nettype wire

// ---- logic/cdu_top.v ----
// configuration download and update engine of the supply sequencer
//
// How it works
// - margin code passes inside limits, else clipped to the nearer limit.
// - margin buffer is off while lower limit exceeds upper limit.
// - margin limits are loaded from nonvolatile memory at start-up download.
// - each setting has staging and active latch; staging written first.
// - download starts only once the undervoltage lockout indication is high.
// - power-up download fills every staging latch before any active latch.
// - then all staging latches copy into active latches in one cycle.
// - 0.5 ms after download the first sequencer state is loaded.
// - bus transactions get no acknowledge until the download has finished; code withholds it until ST_RUN, so also through the 0.5 ms delay.
// - transparent bit set keeps both latches open; writes act at once.
// - transparent bit clear: writes reach staging only, active unchanged.
// - writing 1 to commit bit copies all staging into active together.
// - nonvolatile edits leave volatile latches alone until a reload.
// - a reload overwrites volatile changes with programmed settings.
// - nonvolatile writes follow the same staged or transparent choice.
// - erase enable high lets page erase set a page to ones.
// - reload register bit 0 downloads pages 0 to 4 into latches.
// - nonvolatile address is the register address with upper byte F8.
// - first sequencer state at power-up, next ones when conditions met.
`timescale 1ns/1ps
`default_nettype none
`include "cdu_map.vh"
module cdu_top #(
  parameter [19:0] SEQ_DELAY_CYCLES = `CDU_SEQ_DELAY_CYC
) (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        undervoltage_lockout_ok,
  input  wire        reg_req,
  input  wire        reg_we,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg         reg_done,
  output reg         reg_ack,
  output reg  [7:0]  reg_rdata,
  input  wire        erase_req,
  input  wire [3:0]  erase_page,
  input  wire        seq_cond_met,
  output reg         seq_load_first,
  output reg         seq_load_next,
  output reg         config_ready,
  output wire [47:0] margin_code,
  output wire [5:0]  margin_drive_en
);

  localparam [2:0] ST_WAIT  = 3'd0;
  localparam [2:0] ST_STAGE = 3'd1;
  localparam [2:0] ST_XFER  = 3'd2;
  localparam [2:0] ST_DELAY = 3'd3;
  localparam [2:0] ST_RUN   = 3'd4;
  localparam [2:0] ST_ERASE = 3'd5;
  localparam [2:0] ST_PROG  = 3'd6;

  reg  [7:0]  stage [0:`CDU_RAM_WORDS-1];
  reg  [7:0]  act   [0:`CDU_RAM_WORDS-1];
  reg  [7:0]  nv    [0:`CDU_NV_WORDS-1];
  reg  [7:0]  pbuf  [0:31];

  reg  [2:0]  state;
  reg  [7:0]  idx;
  reg  [19:0] dly;
  reg         reload;
  reg         transp;
  reg         erase_en;
  reg  [3:0]  epage;
  reg  [3:0]  ppage;
  reg  [31:0] pmask;
  reg         tw_pend;
  reg  [7:0]  tw_addr;
  reg  [7:0]  tw_data;
  reg         seq_running;
  integer     i;
  integer     j;

  wire        accept;
  wire        wr;
  wire        rd;
  wire        is_ram;
  wire        is_nv;
  wire        ram_wr;
  wire        nv_wr;
  wire        commit;
  wire        reload_cmd;
  wire        erase_go;
  wire [8:0]  nv_a;
  wire [4:0]  pidx;
  wire [8:0]  nv_pa;

  // only a settled device acknowledges and acts on bus requests
  assign accept     = (state == ST_RUN);
  assign wr         = reg_req & reg_we & accept;
  assign rd         = reg_req & ~reg_we & accept;
  assign is_ram     = (reg_addr[15:8] == 8'h00) &&
                      (reg_addr[7:0] < `CDU_RAM_END);
  assign is_nv      = (reg_addr[15:9] == `CDU_NV_HI);
  assign ram_wr     = wr & is_ram;
  assign nv_wr      = wr & is_nv;
  assign commit     = wr & (reg_addr == `CDU_ADDR_UPDCTRL) &
                      reg_wdata[`CDU_UPD_COMMIT_BIT];
  assign reload_cmd = wr & (reg_addr == `CDU_ADDR_RELOAD) &
                      reg_wdata[`CDU_RELOAD_BIT];
  assign erase_go   = accept & erase_req & erase_en;
  assign nv_a       = reg_addr[8:0];
  assign pidx       = idx[4:0];
  assign nv_pa      = {ppage, pidx};

  // control state
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state         <= ST_WAIT;
      idx           <= 8'h00;
      dly           <= 20'h00000;
      reload        <= 1'b0;
      transp        <= `CDU_UPD_RESET;
      erase_en      <= `CDU_UPD_RESET;
      epage         <= 4'h0;
      ppage         <= 4'h0;
      pmask         <= 32'h00000000;
      tw_pend       <= 1'b0;
      tw_addr       <= 8'h00;
      tw_data       <= 8'h00;
      seq_running    <= 1'b0;
      seq_load_first <= 1'b0;
      seq_load_next  <= 1'b0;
      config_ready   <= 1'b0;
    end else begin
      seq_load_first <= 1'b0;
      seq_load_next  <= 1'b0;
      // in transparent mode the active side follows the staging side one cycle later
      tw_pend <= ram_wr & transp;
      tw_addr <= reg_addr[7:0];
      tw_data <= reg_wdata;
      if (wr && reg_addr == `CDU_ADDR_UPDCTRL) begin
        transp   <= reg_wdata[`CDU_UPD_TRANSP_BIT];
        erase_en <= reg_wdata[`CDU_UPD_ERASE_BIT];
      end
      if (nv_wr && !transp) begin
        // a staged edit to another page drops the older page's bytes
        if (pmask == 32'h00000000 || ppage == nv_a[8:5]) begin
          pmask <= pmask | (32'h00000001 << nv_a[4:0]);
        end else begin
          pmask <= 32'h00000001 << nv_a[4:0];
        end
        ppage <= nv_a[8:5];
      end
      if (seq_running && seq_cond_met) begin
        seq_load_next <= 1'b1;
      end
      case (state)
        ST_WAIT: begin
          if (undervoltage_lockout_ok) begin
            state <= ST_STAGE;
            idx   <= 8'h00;
          end
        end
        ST_STAGE: begin
          // staging side only; active side untouched here
          if (idx == `CDU_RAM_LAST) begin
            state <= ST_XFER;
          end else begin
            idx <= idx + 8'h01;
          end
        end
        ST_XFER: begin
          config_ready <= 1'b1;
          dly          <= 20'h00000;
          if (reload) begin
            state  <= ST_RUN;
            reload <= 1'b0;
          end else begin
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (dly >= SEQ_DELAY_CYCLES - 20'h00001) begin
            state          <= ST_RUN;
            seq_load_first <= 1'b1;
            seq_running    <= 1'b1;
          end else begin
            dly <= dly + 20'h00001;
          end
        end
        ST_RUN: begin
          idx <= 8'h00;
          if (commit && pmask != 32'h00000000) begin
            state <= ST_PROG;
          end else if (reload_cmd) begin
            state  <= ST_STAGE;
            reload <= 1'b1;
          end else if (erase_go) begin
            state <= ST_ERASE;
            epage <= erase_page;
          end
        end
        ST_ERASE: begin
          if (idx[4:0] == `CDU_PAGE_LAST) begin
            state <= ST_RUN;
          end
          idx <= idx + 8'h01;
        end
        ST_PROG: begin
          if (idx[4:0] == `CDU_PAGE_LAST) begin
            state <= ST_RUN;
            pmask <= 32'h00000000;
          end
          idx <= idx + 8'h01;
        end
        default: begin
          state <= ST_WAIT;
        end
      endcase
    end
  end

  // volatile latches; memories carry no reset
  always @(posedge mclk) begin
    if (state == ST_STAGE) begin
      // nonvolatile word n lands in register n
      stage[idx] <= nv[{1'b0, idx}];
    end else if (ram_wr) begin
      stage[reg_addr[7:0]] <= reg_wdata;
    end
    if (state == ST_XFER || commit) begin
      for (i = 0; i < `CDU_RAM_WORDS; i = i + 1) begin
        act[i] <= stage[i];
      end
    end else if (tw_pend) begin
      act[tw_addr] <= tw_data;
    end
  end

  // configuration EEPROM cell; programming only clears bits
  initial begin
    for (j = 0; j < `CDU_NV_WORDS; j = j + 1) begin
      nv[j] = `CDU_NV_BLANK;
    end
  end

  always @(posedge mclk) begin
    if (state == ST_ERASE) begin
      nv[{epage, idx[4:0]}] <= `CDU_NV_BLANK;
    end else if (state == ST_PROG) begin
      if (pmask[pidx]) begin
        nv[nv_pa] <= nv[nv_pa] & pbuf[pidx];
      end
    end else if (nv_wr && transp) begin
      // volatile latches stay as they are until a reload
      nv[nv_a] <= nv[nv_a] & reg_wdata;
    end
    if (nv_wr && !transp) begin
      pbuf[nv_a[4:0]] <= reg_wdata;
    end
  end

  // bus answer, one cycle after the request
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_done  <= 1'b0;
      reg_ack   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      reg_done  <= reg_req;
      reg_ack   <= reg_req & accept;
      reg_rdata <= 8'h00;
      if (rd) begin
        if (is_ram) begin
          reg_rdata <= stage[reg_addr[7:0]];
        end else if (is_nv) begin
          reg_rdata <= nv[nv_a];
        end else if (reg_addr == `CDU_ADDR_UPDCTRL) begin
          // commit never stores, so it reads back as zero
          reg_rdata <= {5'h00, erase_en, 1'b0, transp};
        end else if (reg_addr == `CDU_ADDR_STATUS) begin
          reg_rdata <= {5'h00, (pmask != 32'h00000000),
                        (state != ST_RUN), config_ready};
        end
      end
    end
  end

  // margining channels read the active side only
  genvar g;
  generate
    for (g = 0; g < `CDU_MARGIN_CH; g = g + 1) begin : ch
      cdu_clip u_clip (
        .mclk      (mclk),
        .nrst      (nrst),
        .enable    (config_ready),
        .code      (act[`CDU_ADDR_CODE + g]),
        .lower     (act[`CDU_ADDR_LOWER + g]),
        .upper     (act[`CDU_ADDR_UPPER + g]),
        .clip_code (margin_code[g*8 +: 8]),
        .drive_en  (margin_drive_en[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ---- test/cdu_monitor.sv ----
// assertion checker on the config loader ports
`timescale 1ns/1ps
`default_nettype none
module cdu_monitor #(
  parameter [19:0] SEQ_DELAY_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       reg_req,
  input wire logic       reg_we,
  input wire logic       reg_done,
  input wire logic       reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic       seq_cond_met,
  input wire logic       seq_load_first,
  input wire logic       seq_load_next,
  input wire logic       config_ready,
  input wire logic [5:0] margin_drive_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic        first_done;
  logic [19:0] wait_cnt;
  // cycles of ready seen before the first sequencer load
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_done <= 1'b0;
      wait_cnt   <= 20'h00000;
    end else begin
      if (seq_load_first) first_done <= 1'b1;
      if (config_ready && !first_done) wait_cnt <= wait_cnt + 20'h00001;
    end
  end
  sequence s_req; reg_req; endsequence
  sequence s_answer; ##1 reg_done; endsequence
  a_answer_next_cycle: assert property (s_req |-> s_answer)
    else $error("no answer one cycle after request");
  a_no_stray_done: assert property (!reg_req |=> !reg_done)
    else $error("answer without request");
  a_nack_before_ready: assert property (
    reg_req && !config_ready |=> !reg_ack)
    else $error("acknowledge before download end");
  a_write_reads_zero: assert property (
    reg_req && reg_we |=> reg_rdata == 8'h00)
    else $error("write returned data");
  a_drive_off_early: assert property (
    !config_ready |-> margin_drive_en == 6'h00)
    else $error("margin buffer on before download");
  a_ready_holds: assert property (config_ready |=> config_ready)
    else $error("ready dropped");
  a_first_after_wait: assert property (
    seq_load_first |-> config_ready && !first_done &&
    wait_cnt >= SEQ_DELAY_CYCLES - 20'h1 &&
    wait_cnt <= SEQ_DELAY_CYCLES + 20'h2)
    else $error("first state load at wrong time");
  a_next_follows: assert property (
    seq_cond_met && first_done |=> seq_load_next)
    else $error("next state not loaded");
  a_next_needs_first: assert property (seq_load_next |-> first_done)
    else $error("next state before first");
endmodule
bind cdu_top cdu_monitor #(.SEQ_DELAY_CYCLES(SEQ_DELAY_CYCLES)) u_mon (
  .mclk, .nrst, .reg_req, .reg_we, .reg_done, .reg_ack, .reg_rdata,
  .seq_cond_met, .seq_load_first, .seq_load_next, .config_ready,
  .margin_drive_en);
`default_nettype wire

// ---- test/cdu_host.sv ----
// register bus master standing in for the system controller
`timescale 1ns/1ps
`default_nettype none
module cdu_host (
  input  wire logic        mclk,
  output var  logic        reg_req = 1'b0,
  output var  logic        reg_we = 1'b0,
  output var  logic [15:0] reg_addr = 16'h0000,
  output var  logic [7:0]  reg_wdata = 8'h00,
  output var  logic        erase_req = 1'b0,
  output var  logic [3:0]  erase_page = 4'h0
);
  // one-cycle request; qualifiers turn to junk once taken
  task automatic acc(input logic we, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    reg_req   <= 1'b1;
    reg_we    <= we;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_req   <= 1'b0;
    reg_we    <= ~we;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic erase(input logic [3:0] p);
    @(posedge mclk);
    erase_req  <= 1'b1;
    erase_page <= p;
    @(posedge mclk);
    erase_req  <= 1'b0;
    erase_page <= ~p;
  endtask
endmodule
`default_nettype wire

// ---- test/config_download_update_tb_top.sv ----
// self-checking bench for the config loader
`timescale 1ns/1ps
`default_nettype none
module config_download_update_tb_top;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        undervoltage_lockout_ok = 1'b0;
  logic        seq_cond_met = 1'b0;
  wire         reg_req, reg_we, reg_done, reg_ack, erase_req;
  wire         seq_load_first, seq_load_next, config_ready;
  wire  [15:0] reg_addr;
  wire  [7:0]  reg_wdata, reg_rdata;
  wire  [3:0]  erase_page;
  wire  [47:0] margin_code;
  wire  [5:0]  margin_drive_en;
  int          miscompares = 0;
  int          check_count = 0;
  int          i;
  logic [8:0]  exp_q[$];
  logic [15:0] rnd = 16'h1DA0;
  logic [7:0]  c, e;
  logic [7:0]  edges [0:3] = '{8'h1F, 8'h20, 8'h80, 8'h81};
  always #2.5 mclk = ~mclk;
  cdu_top #(.SEQ_DELAY_CYCLES(20'd20)) DUT (
    .mclk(mclk), .nrst(nrst), .undervoltage_lockout_ok(undervoltage_lockout_ok), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_done(reg_done), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .erase_req(erase_req), .erase_page(erase_page),
    .seq_cond_met(seq_cond_met), .seq_load_first(seq_load_first),
    .seq_load_next(seq_load_next), .config_ready(config_ready),
    .margin_code(margin_code), .margin_drive_en(margin_drive_en));
  cdu_host host (.mclk(mclk), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .erase_req(erase_req), .erase_page(erase_page));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bus(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t bus answer %h expected %h", $time, got, exp);
    end
  endtask
  // expected {ack, rdata} noted before the request goes out
  task automatic rw(input logic we, input logic [15:0] a,
                    input logic [7:0] d, input logic [8:0] x);
    exp_q.push_back(x);
    host.acc(we, a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (reg_done === 1'b1) begin
      if (exp_q.size() > 0) begin
        cmp_bus({reg_ack, reg_rdata}, exp_q.pop_front());
      end else begin
        cmp_bus(9'h1FF, 9'h000);
      end
    end
  end
  initial begin
    #(20000 * 5);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test;
  end
  initial begin
    tick(16);
    nrst <= 1'b1;
    tick(20);
    rw(1'b0, 16'h0058, 8'h00, 9'h000);
    tick(4);
    cmp(config_ready, 1'b0);
    undervoltage_lockout_ok <= 1'b1;
    rw(1'b0, 16'h0058, 8'h00, 9'h000);
    for (i = 0; i < 400 && seq_load_first !== 1'b1; i++) tick(1);
    cmp(seq_load_first, 1'b1);
    cmp(margin_code, {6{8'hFF}});
    cmp(margin_drive_en, 6'h3F);
    $display("test download done");
    rw(1'b1, 16'h0040, 8'h80, 9'h100);
    rw(1'b1, 16'h0048, 8'h20, 9'h100);
    rw(1'b1, 16'h0058, 8'h10, 9'h100);
    rw(1'b0, 16'h0058, 8'h00, 9'h110);
    tick(3);
    cmp(margin_code[7:0], 8'hFF);
    rw(1'b1, 16'h00D7, 8'h02, 9'h100);
    tick(3);
    cmp(margin_code[15:0], 16'hFF20);
    rw(1'b0, 16'h00D7, 8'h00, 9'h100);
    $display("test staged done");
    rw(1'b1, 16'h00D7, 8'h01, 9'h100);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      c = (i < 4) ? edges[i] : rnd[7:0];
      e = (c < 8'h20) ? 8'h20 : (c > 8'h80) ? 8'h80 : c;
      rw(1'b1, 16'h0058, c, 9'h100);
      tick(3);
      cmp(margin_code[7:0], e);
    end
    rw(1'b1, 16'h0048, 8'h90, 9'h100);
    tick(3);
    cmp(margin_drive_en, 6'h3E);
    $display("test transparent done");
    rw(1'b1, 16'hF858, 8'h33, 9'h100);
    rw(1'b1, 16'hF848, 8'h00, 9'h100);
    rw(1'b0, 16'hF858, 8'h00, 9'h133);
    tick(3);
    cmp(margin_drive_en, 6'h3E);
    rw(1'b1, 16'h00D8, 8'h01, 9'h100);
    rw(1'b1, 16'h0058, 8'h00, 9'h000);
    tick(180);
    cmp(margin_code[15:0], 16'hFF33);
    cmp(margin_drive_en, 6'h3F);
    $display("test reload done");
    rw(1'b1, 16'h00D7, 8'h00, 9'h100);
    host.erase(4'h2);
    tick(40);
    rw(1'b0, 16'hF858, 8'h00, 9'h133);
    rw(1'b1, 16'h00D7, 8'h04, 9'h100);
    host.erase(4'h2);
    tick(40);
    rw(1'b0, 16'hF858, 8'h00, 9'h1FF);
    rw(1'b1, 16'hF858, 8'h44, 9'h100);
    rw(1'b0, 16'h00D9, 8'h00, 9'h105);
    rw(1'b0, 16'hF858, 8'h00, 9'h1FF);
    rw(1'b1, 16'h00D7, 8'h02, 9'h100);
    tick(40);
    rw(1'b0, 16'hF858, 8'h00, 9'h144);
    rw(1'b0, 16'h00D9, 8'h00, 9'h101);
    seq_cond_met <= 1'b1;
    tick(1);
    seq_cond_met <= 1'b0;
    tick(1);
    cmp(seq_load_next, 1'b1);
    tick(3);
    $display("test erase done");
    cmp(exp_q.size(), 0);
    finish_test;
  end
endmodule
`default_nettype wire
